// ===== rtl/sbs_pkg.sv
package sbs_pkg;

   localparam int X18_ADDR_W = 20;
   localparam int X18_DATA_W = 18;
   localparam int X36_ADDR_W = 19;
   localparam int X36_DATA_W = 36;
   localparam int LANE_W = 9;
   localparam int MAX_ADDR_W = 20;
   localparam int MAX_DATA_W = 36;
   localparam int MAX_LANES = 4;
   localparam int BURST_W = 2;
   localparam int FIFO_DEPTH = 8;
   localparam int RST_SYNC_W = 2;

   typedef enum logic [1:0] {SBS_IDLE, SBS_READ, SBS_WRITE, SBS_DESEL} sbs_cmd_e;

   typedef struct packed {
      logic [MAX_ADDR_W-1:0] addr;
      logic [MAX_DATA_W-1:0] data;
      logic [MAX_LANES-1:0] lanes;
   } sbs_wr_s;

   typedef struct packed {
      sbs_cmd_e kind;
      sbs_wr_s cmd;
      logic burst_active;
      logic [MAX_ADDR_W-1:0] burst_base;
      logic [BURST_W-1:0] burst_start;
      logic [BURST_W-1:0] burst_cnt;
      logic pipe_valid;
      logic [MAX_DATA_W-1:0] pipe_data;
   } sbs_state_s;

   localparam sbs_state_s STATE_RST = '0;

endpackage

// ===== rtl/sbs_fifo.sv
`timescale 1ns/1ps
module sbs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);

   localparam int PW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << PW) != DEPTH)
      begin : g_bad_depth
         $error("fifo depth must be a power of two, at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW:0] wr;
      logic [PW:0] rd;
   } sbs_fifo_s;

   sbs_fifo_s s_q;
   sbs_fifo_s s_d;
   logic push;
   logic pop;

   // one extra pointer bit tells full from empty
   assign out_valid_o = s_q.wr != s_q.rd;
   assign in_ready_o = (s_q.wr[PW] == s_q.rd[PW]) || (s_q.wr[PW-1:0] != s_q.rd[PW-1:0]);
   assign out_data_o = s_q.mem[s_q.rd[PW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb
   begin
      s_d = s_q;
      if (push)
      begin
         s_d.mem[s_q.wr[PW-1:0]] = in_data_i;
         s_d.wr = s_q.wr + 1'b1;
      end
      if (pop)
      begin
         s_d.rd = s_q.rd + 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_q <= '0;
      end
      else if (ce_i)
      begin
         s_q <= s_d;
      end
   end

endmodule

// ===== rtl/sbs_array.sv
`timescale 1ns/1ps
module sbs_array #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 18,
   parameter int LANES = 2
) (
   input wire logic clk_i,
   input wire logic ce_i,
   input wire logic wr_en_i,
   input wire logic [ADDR_W-1:0] wr_addr_i,
   input wire logic [DATA_W-1:0] wr_data_i,
   input wire logic [LANES-1:0] wr_lanes_i,
   input wire logic [ADDR_W-1:0] rd_addr_i,
   output logic [DATA_W-1:0] rd_data_o
);

   localparam int LW = DATA_W / LANES;

   // contents are never reset, so they survive sleep and a stopped clock
   logic [DATA_W-1:0] mem [2**ADDR_W];

   assign rd_data_o = mem[rd_addr_i];

   always_ff @(posedge clk_i)
   begin
      if (ce_i && wr_en_i)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (wr_lanes_i[i])
            begin
               mem[wr_addr_i][i*LW +: LW] <= wr_data_i[i*LW +: LW];
            end
         end
      end
   end

endmodule

// ===== rtl/sbs_port.sv
`timescale 1ns/1ps
module sbs_port #(
   parameter bit WIDE = 1'b0,
   parameter int FIFO_DEPTH = sbs_pkg::FIFO_DEPTH,
   parameter int ADDR_W = WIDE ? sbs_pkg::X36_ADDR_W : sbs_pkg::X18_ADDR_W,
   parameter int DATA_W = WIDE ? sbs_pkg::X36_DATA_W : sbs_pkg::X18_DATA_W,
   parameter int LANES = DATA_W / sbs_pkg::LANE_W
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] dq_i,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic chip_enable_low_n_i,
   input wire logic processor_address_strobe_n_i,
   input wire logic controller_address_strobe_n_i,
   input wire logic burst_step_n_i,
   input wire logic burst_order_select_i,
   input wire logic flow_through_select_n_i = 1'b1,
   input wire logic byte_write_enable_n_i,
   input wire logic [LANES-1:0] byte_lane_select_n_i,
   input wire logic global_write_n_i,
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i = 1'b0,
   output logic sleep_o,
   output logic write_post_ready_o
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration checks

   generate
      if (!((ADDR_W == sbs_pkg::X18_ADDR_W && DATA_W == sbs_pkg::X18_DATA_W) ||
            (ADDR_W == sbs_pkg::X36_ADDR_W && DATA_W == sbs_pkg::X36_DATA_W)))
      begin : g_bad_org
         $error("organisation must be 1M x 18 or 512K x 36");
      end
      if (LANES * sbs_pkg::LANE_W != DATA_W)
      begin : g_bad_lanes
         $error("lane count does not match data width");
      end
      if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
      begin : g_bad_depth
         $error("post queue depth must be a power of two, at least 2");
      end
      if (WIDE && DATA_W != sbs_pkg::X36_DATA_W)
      begin : g_bad_wide
         $error("wide organisation needs the 36 bit data width");
      end
      if (sbs_pkg::RST_SYNC_W != 2)
      begin : g_bad_sync
         $error("reset release chain is built for two stages");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // reset release

   logic [sbs_pkg::RST_SYNC_W-1:0] rst_sync_q;
   logic rst_n;

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         rst_sync_q <= '0;
      end
      else
      begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[sbs_pkg::RST_SYNC_W-1];

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   function automatic logic [1:0] burst_low(input logic [1:0] start, input logic [1:0] cnt,
                                            input logic interleave);
      if (interleave)
      begin
         burst_low = start ^ cnt;
      end
      else
      begin
         burst_low = 2'(start + cnt);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state and wiring

   sbs_pkg::sbs_state_s s_q;
   sbs_pkg::sbs_state_s s_d;

   logic sleeping;
   logic pipelined;
   logic strobe_p;
   logic strobe_c;
   logic is_write;
   logic [LANES-1:0] wr_lanes;
   logic [DATA_W-1:0] arr_rd;
   logic [DATA_W-1:0] rd_data;
   logic fifo_push;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic drain;
   sbs_pkg::sbs_wr_s fifo_head;
   logic drive;
   logic cap_reads;
   logic cap_blocks;

   // open pins fall back to the port defaults: pipelined, awake
   assign pipelined = flow_through_select_n_i;
   assign sleeping = sleep_request_i;
   assign sleep_o = sleeping;

   // processor strobe is ignored while the chip is not enabled
   assign strobe_p = !processor_address_strobe_n_i && !chip_enable_low_n_i;
   assign strobe_c = !controller_address_strobe_n_i;

   always_comb
   begin
      wr_lanes = '0;
      if (!global_write_n_i)
      begin
         wr_lanes = '1;
      end
      else if (!byte_write_enable_n_i)
      begin
         wr_lanes = ~byte_lane_select_n_i;
      end
   end

   // byte write with no lane selected falls through as a read
   assign is_write = |wr_lanes;

   ////////////////////////////////////////////////////////////////////////////
   // command capture and burst counter

   always_comb
   begin
      s_d = s_q;
      s_d.kind = sbs_pkg::SBS_IDLE;
      s_d.cmd.data = (sbs_pkg::MAX_DATA_W)'(dq_i);
      s_d.cmd.lanes = (sbs_pkg::MAX_LANES)'(wr_lanes);
      if (sleeping)
      begin
         // sleep behaves as a deselect; the burst is held for wake-up
         s_d.kind = sbs_pkg::SBS_DESEL;
      end
      else if (strobe_p)
      begin
         // processor strobe always starts a read, write controls ignored
         s_d.kind = sbs_pkg::SBS_READ;
         s_d.burst_active = 1'b1;
         s_d.burst_base = (sbs_pkg::MAX_ADDR_W)'(addr_i);
         s_d.burst_start = addr_i[1:0];
         s_d.burst_cnt = '0;
         s_d.cmd.addr = (sbs_pkg::MAX_ADDR_W)'(addr_i);
      end
      else if (strobe_c && chip_enable_low_n_i)
      begin
         s_d.kind = sbs_pkg::SBS_DESEL;
         s_d.burst_active = 1'b0;
      end
      else if (strobe_c)
      begin
         s_d.kind = is_write ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
         s_d.burst_active = 1'b1;
         s_d.burst_base = (sbs_pkg::MAX_ADDR_W)'(addr_i);
         s_d.burst_start = addr_i[1:0];
         s_d.burst_cnt = '0;
         s_d.cmd.addr = (sbs_pkg::MAX_ADDR_W)'(addr_i);
      end
      else if (s_q.burst_active)
      begin
         // step held off repeats the current address
         if (!burst_step_n_i)
         begin
            s_d.burst_cnt = 2'(s_q.burst_cnt + 2'h1);
         end
         s_d.kind = is_write ? sbs_pkg::SBS_WRITE : sbs_pkg::SBS_READ;
         s_d.cmd.addr = {s_q.burst_base[sbs_pkg::MAX_ADDR_W-1:2],
                         burst_low(s_q.burst_start, s_d.burst_cnt, burst_order_select_i)};
      end
      // a write with the post queue full is dropped; the controller must watch ready
      if (s_d.kind == sbs_pkg::SBS_WRITE && !fifo_in_ready)
      begin
         s_d.kind = sbs_pkg::SBS_IDLE;
      end
      // read stage feeds the output register one edge later
      s_d.pipe_valid = (s_q.kind == sbs_pkg::SBS_READ);
      if (s_q.kind == sbs_pkg::SBS_READ)
      begin
         s_d.pipe_data = (sbs_pkg::MAX_DATA_W)'(rd_data);
      end
   end

   // plain edge-triggered flops with no dynamic nodes, so a stopped clock loses nothing
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s_q <= sbs_pkg::STATE_RST;
      end
      else if (ce_i)
      begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write posting and array

   assign fifo_push = (s_q.kind == sbs_pkg::SBS_WRITE);
   // no array writes while asleep, so contents stay frozen
   assign drain = !sleeping;
   assign write_post_ready_o = fifo_in_ready;

   sbs_fifo #(
      .WIDTH($bits(sbs_pkg::sbs_wr_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_post (
      .clk_i(mclk_i),
      .rst_n_i(rst_n),
      .ce_i(ce_i),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(s_q.cmd),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(drain),
      .out_data_o(fifo_head)
   );

   sbs_array #(
      .ADDR_W(ADDR_W),
      .DATA_W(DATA_W),
      .LANES(LANES)
   ) u_array (
      .clk_i(mclk_i),
      .ce_i(ce_i),
      .wr_en_i(fifo_out_valid && drain),
      .wr_addr_i(fifo_head.addr[ADDR_W-1:0]),
      .wr_data_i(fifo_head.data[DATA_W-1:0]),
      .wr_lanes_i(fifo_head.lanes[LANES-1:0]),
      .rd_addr_i(s_q.cmd.addr[ADDR_W-1:0]),
      .rd_data_o(arr_rd)
   );

   // a read right behind a write sees the queued lanes, not stale array data
   always_comb
   begin
      rd_data = arr_rd;
      if (fifo_out_valid && fifo_head.addr == s_q.cmd.addr)
      begin
         for (int i = 0; i < LANES; i++)
         begin
            if (fifo_head.lanes[i])
            begin
               rd_data[i*sbs_pkg::LANE_W +: sbs_pkg::LANE_W] =
                  fifo_head.data[i*sbs_pkg::LANE_W +: sbs_pkg::LANE_W];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // data outputs

   // what the capture stage holds decides whether the bus may be driven
   always_comb
   begin
      cap_reads = 1'b0;
      cap_blocks = 1'b0;
      unique case (s_q.kind)
         sbs_pkg::SBS_IDLE:
         begin
            cap_reads = 1'b0;
            cap_blocks = 1'b0;
         end
         sbs_pkg::SBS_READ:
         begin
            cap_reads = 1'b1;
            cap_blocks = 1'b0;
         end
         sbs_pkg::SBS_WRITE:
         begin
            // write data arrives on the same pins, so the bus stays released
            cap_reads = 1'b0;
            cap_blocks = 1'b1;
         end
         sbs_pkg::SBS_DESEL:
         begin
            cap_reads = 1'b0;
            cap_blocks = 1'b1;
         end
      endcase
   end

   always_comb
   begin
      if (pipelined)
      begin
         // deselect or write in the capture stage cuts the register's read short
         drive = s_q.pipe_valid && !cap_blocks;
         dq_o = s_q.pipe_data[DATA_W-1:0];
      end
      else
      begin
         drive = cap_reads;
         dq_o = rd_data;
      end
   end

   // gating is combinational so enable and sleep take effect at once
   assign dq_oe_o = drive && !output_enable_n_i && !sleeping;

endmodule

// ===== test/sbs_port_props.sv
`timescale 1ns/1ps
module sbs_port_props #(
   parameter int LANES = 2
) (
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic ce_i,
   input wire logic dq_oe_o,
   input wire logic sleep_o,
   input wire logic chip_enable_low_n_i,
   input wire logic processor_address_strobe_n_i,
   input wire logic controller_address_strobe_n_i,
   input wire logic flow_through_select_n_i,
   input wire logic byte_write_enable_n_i,
   input wire logic [LANES-1:0] byte_lane_select_n_i,
   input wire logic global_write_n_i,
   input wire logic output_enable_n_i,
   input wire logic sleep_request_i
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);
   logic desel, we, rd_p, rd_c, wr, quiet, shown;
   // decode mirrors the capture priority: sleep, deselect, then strobes
   assign desel = ce_i && (sleep_request_i || (!controller_address_strobe_n_i
      && chip_enable_low_n_i));
   assign we = !global_write_n_i || (!byte_write_enable_n_i && !(&byte_lane_select_n_i));
   assign rd_p = ce_i && !sleep_request_i && !processor_address_strobe_n_i
      && !chip_enable_low_n_i;
   assign rd_c = ce_i && !sleep_request_i && processor_address_strobe_n_i
      && !controller_address_strobe_n_i && !chip_enable_low_n_i && !we;
   assign wr = ce_i && !sleep_request_i && processor_address_strobe_n_i
      && !controller_address_strobe_n_i && !chip_enable_low_n_i && we;
   assign quiet = ce_i && !desel && (rd_p || !we);
   assign shown = !output_enable_n_i && !sleep_request_i;
   ////////////////////////////////////////////////////////////////////////////
   AST_OE_OFF: assert property (output_enable_n_i |-> !dq_oe_o)
      else $error("data driven with output enable off");
   AST_SLEEP_OFF: assert property (sleep_request_i |-> !dq_oe_o && sleep_o)
      else $error("data driven or awake during sleep");
   AST_SLEEP_MIRROR: assert property (sleep_o == sleep_request_i)
      else $error("sleep output does not follow request");
   AST_DESEL: assert property (desel |=> !dq_oe_o)
      else $error("outputs on after deselect");
   AST_SCD: assert property (rd_p && flow_through_select_n_i ##1 desel |=> !dq_oe_o)
      else $error("pipelined read shown past deselect");
   AST_WRITE_HIZ: assert property (wr |=> !dq_oe_o)
      else $error("outputs on during write");
   AST_PIPE: assert property (rd_p && flow_through_select_n_i ##1 quiet ##1
      flow_through_select_n_i |-> !shown || dq_oe_o)
      else $error("pipelined read not shown");
   AST_FLOW: assert property (rd_p && !flow_through_select_n_i
      |=> !shown || flow_through_select_n_i || dq_oe_o)
      else $error("flow read not shown");
   AST_BYTE_READ: assert property (rd_c && !flow_through_select_n_i
      |=> !shown || flow_through_select_n_i || dq_oe_o)
      else $error("byte enable without lanes not a read");
   cover property (rd_p ##1 quiet);
   cover property (desel);
   cover property (wr);
endmodule
bind sbs_port sbs_port_props #(.LANES(LANES)) sbs_port_props_i (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .dq_oe_o(dq_oe_o), .sleep_o(sleep_o),
   .chip_enable_low_n_i(chip_enable_low_n_i),
   .processor_address_strobe_n_i(processor_address_strobe_n_i),
   .controller_address_strobe_n_i(controller_address_strobe_n_i),
   .flow_through_select_n_i(flow_through_select_n_i),
   .byte_write_enable_n_i(byte_write_enable_n_i),
   .byte_lane_select_n_i(byte_lane_select_n_i), .global_write_n_i(global_write_n_i),
   .output_enable_n_i(output_enable_n_i), .sleep_request_i(sleep_request_i)
);

// ===== test/sbs_ctl_model.sv
`timescale 1ns/1ps
module sbs_ctl_model (
   input wire logic mclk_i,
   output logic [19:0] addr_o,
   output logic [17:0] dq_o,
   output logic [5:0] ctl_n_o,
   output logic [1:0] lanes_n_o
);
   // ctl_n_o: step, enable, processor strobe, controller strobe, global write, byte write
   initial
   begin
      addr_o = '0;
      dq_o = '0;
      ctl_n_o = 6'h3F;
      lanes_n_o = 2'h3;
   end
   task automatic cyc(input logic [5:0] c, input logic [19:0] a, input logic [17:0] d,
      input logic [1:0] l);
      @(negedge mclk_i);
      ctl_n_o = c;
      addr_o = a;
      lanes_n_o = l;
      // data not being written flips, so a stale bus never passes for fresh data
      dq_o = (c[1] && c[0]) ? ~dq_o : d;
   endtask
endmodule

// ===== test/sbs_port_bench.sv
`timescale 1ns/1ps
module sbs_port_bench;
   localparam logic [5:0] IDLE = 6'h3F;
   localparam logic [5:0] RD = 6'h27;
   localparam logic [5:0] WR_G = 6'h29;
   localparam logic [5:0] WR_GB = 6'h28;
   localparam logic [5:0] WR_B = 6'h2A;
   localparam logic [5:0] CONT = 6'h0F;
   localparam logic [5:0] DESEL = 6'h3B;
   localparam logic [19:0] A = 20'h0ABC4;
   logic mclk_i, resetn_i, ce, ft_n, oe_n, sleep, order, dq_oe, sleep_o, post_rdy;
   logic [19:0] addr;
   logic [17:0] dq_w, dq_r;
   logic [5:0] ctl;
   logic [1:0] lanes;
   int miscompares = 0;
   int checks = 0;
   sbs_ctl_model sbs_ctl_model_i (.mclk_i(mclk_i), .addr_o(addr), .dq_o(dq_w), .ctl_n_o(ctl),
      .lanes_n_o(lanes));
   sbs_port sbs_port_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce), .addr_i(addr),
      .dq_i(dq_w), .dq_o(dq_r), .dq_oe_o(dq_oe), .chip_enable_low_n_i(ctl[4]),
      .processor_address_strobe_n_i(ctl[3]), .controller_address_strobe_n_i(ctl[2]),
      .burst_step_n_i(ctl[5]), .burst_order_select_i(order), .flow_through_select_n_i(ft_n),
      .byte_write_enable_n_i(ctl[0]), .byte_lane_select_n_i(lanes), .global_write_n_i(ctl[1]),
      .output_enable_n_i(oe_n), .sleep_request_i(sleep), .sleep_o(sleep_o),
      .write_post_ready_o(post_rdy));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
      checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      if (miscompares == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic op(input logic [5:0] k, input logic [19:0] a = A,
      input logic [17:0] d = '0, input logic [1:0] l = 2'h3);
      sbs_ctl_model_i.cyc(k, a, d, l);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_global_pipe();
      // byte write enable with one lane only; global write must still fill both
      op(WR_GB, A, 18'h2A5A5, 2'h2);
      repeat (3) op(IDLE);
      op(RD);
      op(IDLE);
      op(IDLE);
      chk(dq_r, 18'h2A5A5);
      chk(dq_oe, 1'b1);
      oe_n = 1'b1;
      #1 chk(dq_oe, 1'b0);
      oe_n = 1'b0;
      #1 chk(dq_oe, 1'b1);
   endtask
   task automatic t_byte_flow();
      ft_n = 1'b0;
      op(WR_B, A, 18'h3FFFF, 2'h2);
      repeat (3) op(IDLE);
      op(WR_B, A, 18'h00000, 2'h3);
      op(IDLE);
      chk(dq_r, 18'h2A5FF);
      chk(dq_oe, 1'b1);
      op(RD);
      op(IDLE);
      chk(dq_r, 18'h2A5FF);
      op(IDLE);
      ft_n = 1'b1;
   endtask
   task automatic t_burst();
      logic [1:0] k;
      logic [1:0] low;
      for (int i = 0; i < 4; i++)
         op(WR_G, 20'h00100 + 20'(i), 18'h00100 + 18'(i));
      chk(post_rdy, 1'b1);
      repeat (3) op(IDLE);
      for (int o = 0; o < 2; o++)
      begin
         order = o[0];
         op(RD, 20'h00101);
         for (int j = 0; j < 6; j++)
         begin
            op(CONT);
            k = 2'(j - 1);
            low = order ? (2'h1 ^ k) : 2'(2'h1 + k);
            if (j >= 1)
               chk(dq_r, {16'h0040, low});
         end
         op(DESEL);
      end
   endtask
   task automatic t_desel_sleep();
      op(RD);
      op(DESEL);
      op(IDLE);
      chk(dq_oe, 1'b0);
      sleep = 1'b1;
      #1 chk(sleep_o, 1'b1);
      repeat (4) op(RD);
      chk(dq_oe, 1'b0);
      sleep = 1'b0;
      op(RD);
      op(IDLE);
      op(IDLE);
      chk(dq_r, 18'h2A5FF);
   endtask
   task automatic t_hold();
      ce = 1'b0;
      op(WR_G, A, 18'h00000);
      op(IDLE);
      ce = 1'b1;
      op(RD);
      op(IDLE);
      op(IDLE);
      chk(dq_r, 18'h2A5FF);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   initial
   begin
      #400000;
      miscompares++;
      print_verdict();
   end
   initial
   begin
      resetn_i = 1'b0;
      ft_n = 1'b1;
      oe_n = 1'b0;
      sleep = 1'b0;
      order = 1'b0;
      ce = 1'b1;
      repeat (12) @(posedge mclk_i);
      @(negedge mclk_i);
      resetn_i = 1'b1;
      // the synchronised reset needs two edges before the first capture
      repeat (3) op(IDLE);
      t_global_pipe();
      t_byte_flow();
      t_burst();
      t_desel_sleep();
      t_hold();
      print_verdict();
   end
endmodule
